// ==== nif_pkg.sv ====
// Package: offsets, field layouts, reset values, codes and carriers of the flag block
package nif_pkg;

  // ---------------------------------------------------------------
  // Register offsets and field positions
  // ---------------------------------------------------------------
  localparam logic [5:0] NIF_OFS_IRQ_ENABLES = 6'h03;
  localparam logic [5:0] NIF_OFS_IRQ_FLAGS = 6'h05;
  localparam logic [5:0] NIF_OFS_ERRORS = 6'h06;
  localparam logic [5:0] NIF_OFS_STATUS = 6'h07;
  localparam int NIF_BIT_SET_SELECT = 7;
  localparam int NIF_BIT_SECURE_EDGE = 4;
  localparam int NIF_BIT_MODE_DET = 3;
  localparam int NIF_BIT_CRC_DONE = 2;
  localparam int NIF_BIT_FIELD_ON = 1;
  localparam int NIF_BIT_FIELD_OFF = 0;
  localparam int NIF_ERR_WRITE_MISUSE = 7;
  localparam int NIF_ERR_OVERHEAT = 6;
  localparam int NIF_ERR_FIELD_TIMING = 5;
  localparam int NIF_ERR_OVERFLOW = 4;
  localparam int NIF_ERR_COLLISION = 3;
  localparam int NIF_ERR_CHECKSUM = 2;
  localparam int NIF_ERR_PARITY = 1;
  localparam int NIF_ERR_FRAMING = 0;

  // ---------------------------------------------------------------
  // Reset values, constants and command codes
  // ---------------------------------------------------------------
  localparam logic [4:0] NIF_FLAGS_RST = 5'h00;
  localparam logic [4:0] NIF_ENABLES_RST = 5'h00;
  localparam logic [7:0] NIF_ERRORS_RST = 8'h00;
  localparam logic [7:0] NIF_STATUS_RST = 8'h42;
  localparam logic [6:0] NIF_FIFO_DEPTH = 7'h40;
  localparam logic [1:0] NIF_FRAMING_ACTIVE = 2'h1;
  localparam logic [3:0] NIF_CMD_IDLE = 4'h0;
  localparam logic [3:0] NIF_CMD_CALC_CRC = 4'h3;
  localparam logic [3:0] NIF_CMD_AUTO_ANTICOLL = 4'hD;
  localparam logic [3:0] NIF_CMD_CARD_AUTH = 4'hE;

  typedef enum logic [0:0] {
    NIF_DET_IDLE = 1'b0,
    NIF_DET_RUN = 1'b1
  } nif_det_t;

  // Events and levels from neighbouring engines, same clock
  typedef struct packed {
    logic command_start;
    logic [3:0] command;
    logic command_done;
    logic host_fifo_write;
    logic internal_fifo_write;
    logic fifo_full;
    logic [6:0] fifo_level;
    logic rf_turnaround;
    logic overheat;
    logic overheat_clear;
    logic active_mode;
    logic counterpart_field_late;
    logic rate_above_106;
    logic rx_startup;
    logic collision_detected;
    logic rx_crc_fail;
    logic parity_fail;
    logic sof_bad;
    logic byte_length_violation;
    logic card_scheme_212;
    logic byte_count_bad;
    logic miller_short_pulses;
    logic crc_data_done;
    logic mode_identified;
    logic rf_reset;
    logic crc_ok;
    logic crc_ready;
    logic timer_active;
    logic primary_irq_pending;
  } nif_eng_t;

  // Configuration bits held in other register groups
  typedef struct packed {
    logic receive_checksum_enable;
    logic sync_detect_enable;
    logic reader_role;
    logic [1:0] receive_framing_field;
    logic [1:0] transmit_framing_field;
    logic [5:0] water_level;
  } nif_cfg_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] rdata;
    logic [4:0] flags;
    logic [4:0] enables;
    logic [7:0] errors;
    logic [7:0] status;
    logic [3:0] command;
    nif_det_t det;
    logic antenna_off;
    logic [1:0] sig_sync;
    logic sig_prev;
    logic [1:0] field_sync;
    logic field_prev;
    logic [1:0] freq_sync;
  } nif_state_t;

endpackage

// ==== nif_flags.sv ====
// Secondary interrupt flags, last-command errors and primary status of the frontend
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps

// Overview of operation
// - Flag write: bit 7 high sets marked flags, low clears them
// - Any edge on secure element input raises secure-input flag
// - Mode detector success raises mode-detected flag
// - Mode detector starts by auto-anticollision or RF reset, stops once mode found
// - Mode detector restarts after every RF reset
// - CRC flag set when CRC command runs and all data processed
// - Field-on flag on field appearing, field-off flag on vanishing
// - Error register read-only, resets to zero, one error per bit
// - Write-misuse error on host FIFO write in anticollision, auth, turnaround
// - Overheat sets overheat error and switches antenna drivers off
// - Field timing error in active mode when framing field is 01
// - Overflow error on any FIFO write while FIFO full
// - Collision error, cleared at receiver start, forced one above 106
// - Checksum error when checking enabled and fails, cleared at start
// - Parity error on failed parity at 106, cleared at receiver start
// - Framing error on bad start of frame at 106, cleared at start
// - Framing error during auto-anticollision when reader role selected
// - Framing error during authentication on wrong byte count
// - Framing error when Miller decoder sees two pulses too close
// - Command start clears all errors but overheat; software cannot set
// - Status read-only, fixed bit layout, reset pattern X100X01X
// - Interrupt-pending bit when any enabled source is asserted
// - Nearly-full bit when 64 minus fill level within water level
module nif_flags
  import nif_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_secure_element_input,
  input wire logic i_field_detect,
  input wire logic i_freq_in_range,
  input wire nif_eng_t i_eng,
  input wire nif_cfg_t i_cfg,
  output logic [7:0] o_rdata,
  output logic o_antenna_drivers_off,
  output logic o_mode_detector_on
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Register write decode
  function automatic logic wr_hit(input logic wr, input logic [5:0] a, input logic [5:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  nif_state_t s_q;
  nif_state_t s_d;

  logic sig_edge;
  logic field_rise;
  logic field_fall;
  logic [4:0] hw_flag_set;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic [3:0] cur_cmd;
  logic hi_alert;
  logic lo_alert;
  logic irq_pending;
  logic framing_active;

  // ---------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------

  // Edges on the synchronised pins
  assign sig_edge = s_q.sig_sync[1] ^ s_q.sig_prev;
  assign field_rise = s_q.field_sync[1] && !s_q.field_prev;
  assign field_fall = !s_q.field_sync[1] && s_q.field_prev;

  // Command in force this cycle
  assign cur_cmd = s_q.command;

  // Active framing selected on either direction
  assign framing_active = (i_cfg.receive_framing_field == NIF_FRAMING_ACTIVE) ||
                          (i_cfg.transmit_framing_field == NIF_FRAMING_ACTIVE);

  // Hardware flag sources
  always_comb
  begin
    hw_flag_set = 5'h00;
    hw_flag_set[NIF_BIT_SECURE_EDGE] = sig_edge;
    hw_flag_set[NIF_BIT_MODE_DET] = (s_q.det == NIF_DET_RUN) && i_eng.mode_identified;
    hw_flag_set[NIF_BIT_CRC_DONE] = (cur_cmd == NIF_CMD_CALC_CRC) && i_eng.crc_data_done;
    hw_flag_set[NIF_BIT_FIELD_ON] = field_rise;
    hw_flag_set[NIF_BIT_FIELD_OFF] = field_fall;
  end

  // Error sources
  always_comb
  begin
    err_set = 8'h00;
    err_set[NIF_ERR_WRITE_MISUSE] = i_eng.host_fifo_write &&
      ((cur_cmd == NIF_CMD_AUTO_ANTICOLL) || (cur_cmd == NIF_CMD_CARD_AUTH) ||
       i_eng.rf_turnaround);
    err_set[NIF_ERR_OVERHEAT] = i_eng.overheat;
    err_set[NIF_ERR_FIELD_TIMING] = i_eng.active_mode && framing_active &&
      i_eng.counterpart_field_late;
    err_set[NIF_ERR_OVERFLOW] = (i_eng.host_fifo_write || i_eng.internal_fifo_write) &&
      i_eng.fifo_full;
    err_set[NIF_ERR_COLLISION] = i_eng.collision_detected || i_eng.rate_above_106;
    err_set[NIF_ERR_CHECKSUM] = i_cfg.receive_checksum_enable && i_eng.rx_crc_fail;
    err_set[NIF_ERR_PARITY] = i_eng.parity_fail && !i_eng.rate_above_106;
    err_set[NIF_ERR_FRAMING] =
      (i_eng.sof_bad && !i_eng.rate_above_106) ||
      (i_cfg.sync_detect_enable && i_eng.byte_length_violation &&
       (i_eng.card_scheme_212 || (i_eng.active_mode && i_eng.rate_above_106))) ||
      ((cur_cmd == NIF_CMD_AUTO_ANTICOLL) && i_cfg.reader_role) ||
      ((cur_cmd == NIF_CMD_CARD_AUTH) && i_eng.byte_count_bad) ||
      i_eng.miller_short_pulses;
  end

  // Error clears: command start, receiver start-up and overheat clear
  always_comb
  begin
    err_clr = 8'h00;
    if (i_eng.command_start)
    begin
      err_clr = 8'hFF;
      err_clr[NIF_ERR_OVERHEAT] = 1'b0;
    end
    if (i_eng.rx_startup)
    begin
      err_clr[NIF_ERR_COLLISION] = 1'b1;
      err_clr[NIF_ERR_CHECKSUM] = 1'b1;
      err_clr[NIF_ERR_PARITY] = 1'b1;
      err_clr[NIF_ERR_FRAMING] = 1'b1;
    end
    if (i_eng.overheat_clear)
    begin
      err_clr[NIF_ERR_OVERHEAT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Status terms
  // ---------------------------------------------------------------

  // FIFO water marks
  assign hi_alert = (NIF_FIFO_DEPTH - i_eng.fifo_level) <= {1'b0, i_cfg.water_level};
  assign lo_alert = i_eng.fifo_level <= {1'b0, i_cfg.water_level};

  // Any enabled source asking for attention
  assign irq_pending = i_eng.primary_irq_pending ||
                       (|(s_q.flags & s_q.enables));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Pin synchronisers and edge history
    s_d.sig_sync = {s_q.sig_sync[0], i_secure_element_input};
    s_d.sig_prev = s_q.sig_sync[1];
    s_d.field_sync = {s_q.field_sync[0], i_field_detect};
    s_d.field_prev = s_q.field_sync[1];
    s_d.freq_sync = {s_q.freq_sync[0], i_freq_in_range};

    // Command tracking
    if (i_eng.command_start)
    begin
      s_d.command = i_eng.command;
    end
    else if (i_eng.command_done)
    begin
      s_d.command = NIF_CMD_IDLE;
    end

    // Data mode detector
    unique case (s_q.det)
      NIF_DET_IDLE:
      begin
        if ((i_eng.command_start && (i_eng.command == NIF_CMD_AUTO_ANTICOLL)) ||
            i_eng.rf_reset)
        begin
          s_d.det = NIF_DET_RUN;
        end
      end
      NIF_DET_RUN:
      begin
        if (i_eng.rf_reset)
        begin
          s_d.det = NIF_DET_RUN;
        end
        else if (i_eng.mode_identified)
        begin
          s_d.det = NIF_DET_IDLE;
        end
      end
    endcase

    // Software enable register
    if (wr_hit(i_wr, i_addr, NIF_OFS_IRQ_ENABLES))
    begin
      s_d.enables = i_wdata[4:0];
    end

    // Flags: software set or clear, hardware set wins
    if (wr_hit(i_wr, i_addr, NIF_OFS_IRQ_FLAGS))
    begin
      if (i_wdata[NIF_BIT_SET_SELECT])
      begin
        s_d.flags = s_q.flags | i_wdata[4:0];
      end
      else
      begin
        s_d.flags = s_q.flags & ~i_wdata[4:0];
      end
    end
    s_d.flags = s_d.flags | hw_flag_set;

    // Errors: clears first, sets win; no software path
    s_d.errors = (s_q.errors & ~err_clr) | err_set;
    s_d.antenna_off = s_d.errors[NIF_ERR_OVERHEAT];

    // Status snapshot
    s_d.status = {s_q.freq_sync[1], i_eng.crc_ok, i_eng.crc_ready, irq_pending,
                  i_eng.timer_active, s_q.field_sync[1], hi_alert, lo_alert};

    // Read data stands only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        NIF_OFS_IRQ_ENABLES: s_d.rdata = {3'h0, s_q.enables};
        NIF_OFS_IRQ_FLAGS: s_d.rdata = {3'h0, s_q.flags};
        NIF_OFS_ERRORS: s_d.rdata = s_q.errors;
        NIF_OFS_STATUS: s_d.rdata = s_q.status;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      s_q.rdata <= 8'h00;
      s_q.flags <= NIF_FLAGS_RST;
      s_q.enables <= NIF_ENABLES_RST;
      s_q.errors <= NIF_ERRORS_RST;
      s_q.status <= NIF_STATUS_RST;
      s_q.command <= NIF_CMD_IDLE;
      s_q.det <= NIF_DET_IDLE;
      s_q.antenna_off <= 1'b0;
      s_q.sig_sync <= 2'h0;
      s_q.sig_prev <= 1'b0;
      s_q.field_sync <= 2'h0;
      s_q.field_prev <= 1'b0;
      s_q.freq_sync <= 2'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = s_q.rdata;
  assign o_antenna_drivers_off = s_q.antenna_off;
  assign o_mode_detector_on = (s_q.det == NIF_DET_RUN);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  // Set write marks flags
  a_flag_set_write: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_wr && (i_addr == NIF_OFS_IRQ_FLAGS) && i_wdata[7])
    |=> ((s_q.flags & $past(i_wdata[4:0])) == $past(i_wdata[4:0])))
    else $error("flag set write lost");

  // Clear write drops a flag with no hardware event
  a_flag_clear_write: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_wr && (i_addr == NIF_OFS_IRQ_FLAGS) && !i_wdata[7] && i_wdata[2] &&
     !((s_q.command == NIF_CMD_CALC_CRC) && i_eng.crc_data_done))
    |=> !s_q.flags[NIF_BIT_CRC_DONE])
    else $error("crc flag not cleared");

  // Pin edge reaches its flag
  a_secure_edge_flag: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    $changed(i_secure_element_input) ##3 1'b1 |-> s_q.flags[NIF_BIT_SECURE_EDGE])
    else $error("secure input edge missed");

  // Detector stops and flags once the mode is found
  a_mode_det_stop: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    ((s_q.det == NIF_DET_RUN) && i_eng.mode_identified && !i_eng.rf_reset)
    |=> (!o_mode_detector_on && s_q.flags[NIF_BIT_MODE_DET]))
    else $error("mode detector did not stop");

  // Detector restarts after RF reset
  a_mode_det_restart: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_eng.rf_reset |=> o_mode_detector_on)
    else $error("mode detector not restarted");

  // Field appearance sets field-on flag
  a_field_on_flag: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    $rose(s_q.field_sync[1]) |=> s_q.flags[NIF_BIT_FIELD_ON])
    else $error("field on flag missed");

  // Field disappearance sets field-off flag; a reset that drops the synchroniser is no event
  a_field_off_flag: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    ($fell(s_q.field_sync[1]) && !$past(i_sys_rst)) |=> s_q.flags[NIF_BIT_FIELD_OFF])
    else $error("field off flag missed");

  // Overheat forces error and antenna off
  a_overheat_antenna: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_eng.overheat |=> (s_q.errors[NIF_ERR_OVERHEAT] && o_antenna_drivers_off))
    else $error("overheat not handled");

  // Full FIFO write flags overflow
  a_fifo_overflow: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    ((i_eng.host_fifo_write || i_eng.internal_fifo_write) && i_eng.fifo_full)
    |=> s_q.errors[NIF_ERR_OVERFLOW])
    else $error("overflow error missed");

  // Command start keeps overheat, clears an idle misuse error
  a_cmd_start_clear: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_eng.command_start && !i_eng.host_fifo_write && !i_eng.overheat_clear && !i_eng.overheat)
    |=> (!s_q.errors[NIF_ERR_WRITE_MISUSE] &&
         (s_q.errors[NIF_ERR_OVERHEAT] == $past(s_q.errors[NIF_ERR_OVERHEAT]))))
    else $error("command start clear wrong");

  // Error read returns the register of the previous cycle
  a_error_readback: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_rd && (i_addr == NIF_OFS_ERRORS)) |=> (o_rdata == $past(s_q.errors)))
    else $error("error readback wrong");

  // Receiver start drops a parity error unless a new one arrives
  a_rx_start_clear: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_eng.rx_startup && !i_eng.parity_fail) |=> !s_q.errors[NIF_ERR_PARITY])
    else $error("parity error not cleared");

  // Nearly-full status follows the water mark
  a_hi_alert_status: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    !i_sys_rst |=> (s_q.status[1] ==
      ((NIF_FIFO_DEPTH - $past(i_eng.fifo_level)) <= {1'b0, $past(i_cfg.water_level)})))
    else $error("nearly full status wrong");

  // Reserved flag bits read zero
  a_reserved_zero: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_rd && (i_addr == NIF_OFS_IRQ_FLAGS)) |=> (o_rdata[7:5] == 3'h0))
    else $error("reserved bits not zero");

endmodule

// ==== nif_host_model.sv ====
// Host controller model: register bus master for the flag block
`timescale 1ns/10ps

module nif_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // ---------------------------------------------------------------
  // Bus idle state
  // ---------------------------------------------------------------
  initial
  begin
    o_addr = 6'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; software owns flag clearing
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d; // Released data no longer shows the value
  endtask

  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule

// ==== nif_flags_test.sv ====
// Self-checking testbench of the flag, error and status block
`timescale 1ns/10ps

module nif_flags_test;
  import nif_pkg::*;
  typedef struct {
    logic [3:0] cmd;
    nif_eng_t ev;
    nif_cfg_t cfg;
    logic [5:0] ofs;
    logic [7:0] exp;
  } nif_row_t;
  localparam logic [5:0] OER = NIF_OFS_ERRORS;
  localparam logic [5:0] OFL = NIF_OFS_IRQ_FLAGS;
  localparam logic [5:0] OST = NIF_OFS_STATUS;
  localparam nif_cfg_t C0 = '0;
  localparam nif_cfg_t CFR = nif_cfg_t'{receive_framing_field:NIF_FRAMING_ACTIVE, default:'0};
  localparam nif_cfg_t CCK = nif_cfg_t'{receive_checksum_enable:1'h1, default:'0};
  localparam nif_cfg_t CSY = nif_cfg_t'{sync_detect_enable:1'h1, default:'0};
  localparam nif_cfg_t CRO = nif_cfg_t'{reader_role:1'h1, default:'0};
  logic mclk, sys_rst, wr, rd, sec_in, field_in, freq_in, ant_off, det_on;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, d;
  nif_eng_t eng, idle;
  nif_cfg_t cfg;
  nif_row_t rows[$];
  int mismatches = 0;
  int cmp_count = 0;

  nif_flags dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_secure_element_input(sec_in), .i_field_detect(field_in),
    .i_freq_in_range(freq_in), .i_eng(eng), .i_cfg(cfg), .o_rdata(rdata),
    .o_antenna_drivers_off(ant_off), .o_mode_detector_on(det_on));
  nif_host_model host (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  // ---------------------------------------------------------------
  // Clock, comparison and closing report
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Engine pulse for one cycle, then back to idle levels
  task automatic pulse(input nif_eng_t e);
    @(posedge mclk);
    eng <= e;
    @(posedge mclk);
    eng <= idle;
  endtask

  task automatic add(input logic [3:0] c, input nif_eng_t e, input nif_cfg_t g,
                     input logic [5:0] o, input logic [7:0] x);
    rows.push_back('{c, e, g, o, x});
  endtask

  // Pin edge, synchroniser delay, flag read and clear
  task automatic pin_step(input int which, input logic v, input logic [7:0] exp);
    @(posedge mclk);
    if (which == 0)
      sec_in <= v;
    else
      field_in <= v;
    repeat (4) @(posedge mclk);
    host.rd(OFL, d);
    check(d, exp);
    host.wr(OFL, 8'h1F);
  endtask

  task automatic stat(input logic [6:0] lvl, input logic [7:0] exp);
    @(posedge mclk);
    idle.fifo_level = lvl;
    eng <= idle;
    repeat (4) @(posedge mclk);
    host.rd(OST, d);
    check(d, exp);
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    sec_in = 1'b0;
    field_in = 1'b0;
    freq_in = 1'b0;
    eng = '0;
    idle = '0;
    cfg = '0;
    add(NIF_CMD_IDLE, nif_eng_t'{host_fifo_write:1'h1, fifo_full:1'h1, default:'0}, C0, OER,
        8'h10);
    add(NIF_CMD_IDLE, nif_eng_t'{internal_fifo_write:1'h1, fifo_full:1'h1, default:'0}, C0,
        OER, 8'h10);
    add(NIF_CMD_CARD_AUTH, nif_eng_t'{host_fifo_write:1'h1, default:'0}, C0, OER, 8'h80);
    add(NIF_CMD_AUTO_ANTICOLL, nif_eng_t'{host_fifo_write:1'h1, default:'0}, C0, OER,
        8'h80);
    add(NIF_CMD_IDLE, nif_eng_t'{host_fifo_write:1'h1, rf_turnaround:1'h1, default:'0}, C0,
        OER, 8'h80);
    add(NIF_CMD_IDLE, nif_eng_t'{active_mode:1'h1, counterpart_field_late:1'h1, default:'0},
        CFR, OER, 8'h20);
    add(NIF_CMD_IDLE, nif_eng_t'{active_mode:1'h1, counterpart_field_late:1'h1, default:'0},
        C0, OER, 8'h00);
    add(NIF_CMD_IDLE, nif_eng_t'{collision_detected:1'h1, default:'0}, C0, OER, 8'h08);
    add(NIF_CMD_IDLE, nif_eng_t'{parity_fail:1'h1, rate_above_106:1'h1, default:'0}, C0, OER,
        8'h08);
    add(NIF_CMD_IDLE, nif_eng_t'{rx_crc_fail:1'h1, default:'0}, CCK, OER, 8'h04);
    add(NIF_CMD_IDLE, nif_eng_t'{rx_crc_fail:1'h1, default:'0}, C0, OER, 8'h00);
    add(NIF_CMD_IDLE, nif_eng_t'{parity_fail:1'h1, default:'0}, C0, OER, 8'h02);
    add(NIF_CMD_IDLE, nif_eng_t'{sof_bad:1'h1, default:'0}, C0, OER, 8'h01);
    add(NIF_CMD_IDLE, nif_eng_t'{byte_length_violation:1'h1, card_scheme_212:1'h1,
        default:'0}, CSY, OER, 8'h01);
    add(NIF_CMD_AUTO_ANTICOLL, '0, CRO, OER, 8'h01);
    add(NIF_CMD_CARD_AUTH, nif_eng_t'{byte_count_bad:1'h1, default:'0}, C0, OER, 8'h01);
    add(NIF_CMD_IDLE, nif_eng_t'{miller_short_pulses:1'h1, default:'0}, C0, OER, 8'h01);
    add(NIF_CMD_CALC_CRC, nif_eng_t'{crc_data_done:1'h1, default:'0}, C0, OFL, 8'h04);
    add(NIF_CMD_IDLE, nif_eng_t'{crc_data_done:1'h1, default:'0}, C0, OFL, 8'h00);
    add(NIF_CMD_AUTO_ANTICOLL, nif_eng_t'{mode_identified:1'h1, default:'0}, C0, OFL,
        8'h08);
    add(NIF_CMD_IDLE, nif_eng_t'{mode_identified:1'h1, default:'0}, C0, OFL, 8'h00);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    host.rd(OER, d);
    check(d, 8'h00);
    // Table of event cases, each after a fresh command start
    foreach (rows[i])
    begin
      @(posedge mclk);
      cfg <= rows[i].cfg;
      host.wr(OFL, 8'h1F);
      pulse(nif_eng_t'{command_start:1'h1, command:rows[i].cmd, default:'0});
      pulse(rows[i].ev);
      host.rd(rows[i].ofs, d);
      check(d, rows[i].exp);
    end
    // Set, clear and reserved flag bits, pending bit
    host.wr(OFL, 8'hFF);
    host.rd(OFL, d);
    check(d, 8'h1F);
    host.wr(OFL, 8'h0A);
    host.rd(OFL, d);
    check(d, 8'h15);
    host.wr(NIF_OFS_IRQ_ENABLES, 8'h04);
    repeat (2) @(posedge mclk);
    host.rd(OST, d);
    check({7'h00, d[4]}, 8'h01);
    host.wr(OFL, 8'h1F);
    repeat (2) @(posedge mclk);
    host.rd(OST, d);
    check({7'h00, d[4]}, 8'h00);
    // Pin edges both ways
    pin_step(0, 1'b1, 8'h10);
    pin_step(0, 1'b0, 8'h10);
    pin_step(1, 1'b1, 8'h02);
    pin_step(1, 1'b0, 8'h01);
    // Overheat survives command start and software writes
    pulse(nif_eng_t'{overheat:1'h1, default:'0});
    host.rd(OER, d);
    check(d, 8'h40);
    check({7'h00, ant_off}, 8'h01);
    pulse(nif_eng_t'{command_start:1'h1, command:NIF_CMD_IDLE, default:'0});
    host.wr(OER, 8'hFF);
    host.rd(OER, d);
    check(d, 8'h40);
    pulse(nif_eng_t'{overheat_clear:1'h1, default:'0});
    host.rd(OER, d);
    check(d, 8'h00);
    check({7'h00, ant_off}, 8'h00);
    host.wr(6'h3F, 8'hFF);
    host.rd(6'h3F, d);
    check(d, 8'h00);
    // Detector restart by RF reset, stop on mode found
    pulse(nif_eng_t'{rf_reset:1'h1, default:'0});
    #1 check({7'h00, det_on}, 8'h01);
    pulse(nif_eng_t'{mode_identified:1'h1, default:'0});
    #1 check({7'h00, det_on}, 8'h00);
    host.rd(OFL, d);
    check(d, 8'h08);
    // Receiver start clears receive errors, keeps overheat
    pulse(nif_eng_t'{overheat:1'h1, collision_detected:1'h1, parity_fail:1'h1, sof_bad:1'h1,
          default:'0});
    host.rd(OER, d);
    check(d, 8'h4B);
    pulse(nif_eng_t'{rx_startup:1'h1, default:'0});
    host.rd(OER, d);
    check(d, 8'h40);
    // Status layout and fill-level boundaries
    host.wr(OFL, 8'h1F);
    idle.crc_ok = 1'h1;
    idle.timer_active = 1'h1;
    @(posedge mclk);
    freq_in <= 1'b1;
    field_in <= 1'b1;
    cfg <= nif_cfg_t'{water_level:6'h04, default:'0};
    stat(7'h3C, 8'hCE);
    stat(7'h3B, 8'hCC);
    stat(7'h04, 8'hCD);
    stat(7'h05, 8'hCC);
    // Reset in mid-run drops flags and errors
    host.wr(OFL, 8'h90);
    pulse(nif_eng_t'{overheat:1'h1, default:'0});
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    host.rd(OFL, d);
    check(d, 8'h00);
    host.rd(OER, d);
    check(d, 8'h00);
    check({7'h00, ant_off}, 8'h00);
    report_and_stop();
  end
endmodule
